// ### src/pinmux_pkg.sv
// Constants shared by the port B pin function multiplexer.
// Assumes a 32-bit APB register bus and 16 multiplexed pins.
package pinmux_pkg;

  // Port width and field layout
  localparam int unsigned PIN_COUNT  = 16;
  localparam int unsigned HALF_PINS  = 8;
  localparam int unsigned FIELD_W    = 2;
  localparam int unsigned REG_W      = 16;
  localparam int unsigned ADDR_W     = 12;
  localparam int unsigned DATA_W     = 32;
  localparam int unsigned SYNC_DEPTH = 2;

  // Register byte offsets
  localparam logic [ADDR_W-1:0] OFS_UPPER_FUNC = 12'h000;
  localparam logic [ADDR_W-1:0] OFS_LOWER_FUNC = 12'h004;
  localparam logic [ADDR_W-1:0] OFS_DIRECTION  = 12'h008;
  localparam logic [ADDR_W-1:0] OFS_OUT_DATA   = 12'h00c;
  localparam logic [ADDR_W-1:0] OFS_PIN_LEVEL  = 12'h010;

  // Reset values
  localparam logic [REG_W-1:0] RST_FUNC      = 16'h0000;
  localparam logic [REG_W-1:0] RST_DIRECTION = 16'h0000;
  localparam logic [REG_W-1:0] RST_OUT_DATA  = 16'h0000;

  // Function codes
  localparam logic [FIELD_W-1:0] MODE_GPIO = 2'h0;
  localparam logic [FIELD_W-1:0] MODE_ALT1 = 2'h1;
  localparam logic [FIELD_W-1:0] MODE_ALT2 = 2'h2;
  localparam logic [FIELD_W-1:0] MODE_ALT3 = 2'h3;

  // Legal codes per pin, four bits per pin indexed by code, pin 15 first
  localparam logic [4*PIN_COUNT-1:0] MODE_LEGAL = {
    4'h5, 4'h5, 4'h5, 4'hf, 4'hf, 4'h7, 4'h7, 4'h7,
    4'hf, 4'hf, 4'hf, 4'hf, 4'hf, 4'hf, 4'hf, 4'hf
  };

  // Pin indices of the upper half
  localparam int unsigned PIN_SCK   = 15;
  localparam int unsigned PIN_RXD   = 14;
  localparam int unsigned PIN_TXD   = 13;
  localparam int unsigned PIN_P12   = 12;
  localparam int unsigned PIN_P11   = 11;
  localparam int unsigned PIN_P10   = 10;
  localparam int unsigned PIN_P9    = 9;
  localparam int unsigned PIN_P8    = 8;

  // Unmapped addresses answer with an error
  function automatic logic addr_hit(input logic [ADDR_W-1:0] addr);
    addr_hit = (addr == OFS_UPPER_FUNC) || (addr == OFS_LOWER_FUNC) ||
               (addr == OFS_DIRECTION)  || (addr == OFS_OUT_DATA)   ||
               (addr == OFS_PIN_LEVEL);
  endfunction : addr_hit

endpackage : pinmux_pkg

// ### src/pin_sync.sv
// Two-stage synchroniser for the pad input levels.
// Assumes pad levels change with no relation to sys_clk_i.
`timescale 1ns/1ps
module pin_sync (
  // Clock and reset
  input  wire logic                                sys_clk_i,
  input  wire logic                                reset_n_i,
  // Levels
  input  wire logic [pinmux_pkg::PIN_COUNT-1:0]    async_i,
  output logic      [pinmux_pkg::PIN_COUNT-1:0]    sync_o
);
  import pinmux_pkg::*;

  logic [PIN_COUNT-1:0] meta_q;
  logic [PIN_COUNT-1:0] sync_q;

  // First stage feeds only the second stage
  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      meta_q <= '0;
      sync_q <= '0;
    end else begin
      meta_q <= async_i;
      sync_q <= meta_q;
    end
  end

  assign sync_o = sync_q;

endmodule : pin_sync

// ### src/apb_port.sv
// APB slave front end: decode, strobes and registered read answer.
// Assumes a standard APB master; the slave never inserts wait states.
`timescale 1ns/1ps
module apb_port (
  // Clock and reset
  input  wire logic                             sys_clk_i,
  input  wire logic                             reset_n_i,
  // APB
  input  wire logic                             psel_i,
  input  wire logic                             penable_i,
  input  wire logic                             pwrite_i,
  input  wire logic [pinmux_pkg::ADDR_W-1:0]    paddr_i,
  output logic      [pinmux_pkg::DATA_W-1:0]    prdata_o,
  output logic                                  pready_o,
  output logic                                  pslverr_o,
  // Register side
  input  wire logic [pinmux_pkg::DATA_W-1:0]    rd_data_i,
  output logic                                  wr_stb_o
);
  import pinmux_pkg::*;

  logic              setup;
  logic [DATA_W-1:0] prdata_d;
  logic [DATA_W-1:0] prdata_q;
  logic              err_d;
  logic              err_q;

  assign setup = psel_i && !penable_i;

  // Read data and error are caught in the setup cycle so they come from flops
  always_comb begin
    prdata_d = prdata_q;
    err_d    = err_q;
    if (setup) begin
      err_d    = !addr_hit(paddr_i);
      prdata_d = (!pwrite_i && addr_hit(paddr_i)) ? rd_data_i : '0;
    end
  end

  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      prdata_q <= '0;
      err_q    <= 1'b0;
    end else begin
      prdata_q <= prdata_d;
      err_q    <= err_d;
    end
  end

  assign pready_o  = 1'b1;
  assign prdata_o  = prdata_q;
  assign pslverr_o = psel_i && penable_i && err_q;
  assign wr_stb_o  = psel_i && penable_i && pwrite_i && addr_hit(paddr_i);

endmodule : apb_port

// ### src/port_b_pinmux.sv
// Port B pin function multiplexer: two function-select registers steer
// each of 16 pads between general I/O and peripheral functions.
// Assumes reset_n_i is the power-on reset; manual reset, standby and sleep
// are not seen here, so the registers hold through them.
// Notes on behaviour
// - Two 16-bit registers, 2-bit field per pin
// - Only power-on reset clears both registers
// - Upper register: pin 15 high pair, down
// - Lower register: pin 7 high pair, down
// - Code 00 selects general I/O
// - Pin 15 code 10: async serial clock
// - Pin 14 code 10: async receive data
// - Pin 13 code 10: async transmit data
// - Pin 12: sync rx clock, RTS, status1
// - Pin 11: sync frame sync, CTS, status0
// - Pin 10: sync rx data, timer1 A
// - Pin 9: sync tx clock, timer1 B
// - Pin 9 timer mode may be clock C
// - Pin 8: sync tx frame sync, timer2 A
// - Direction applies only in general I/O
`timescale 1ns/1ps
module port_b_pinmux (
  // Clock and reset
  input  wire logic                             sys_clk_i,
  input  wire logic                             reset_n_i,
  // APB
  input  wire logic                             psel_i,
  input  wire logic                             penable_i,
  input  wire logic                             pwrite_i,
  input  wire logic [pinmux_pkg::ADDR_W-1:0]    paddr_i,
  input  wire logic [pinmux_pkg::DATA_W-1:0]    pwdata_i,
  input  wire logic [3:0]                       pstrb_i,
  output logic      [pinmux_pkg::DATA_W-1:0]    prdata_o,
  output logic                                  pready_o,
  output logic                                  pslverr_o,
  // Pads
  input  wire logic [pinmux_pkg::PIN_COUNT-1:0] pin_in_i,
  output logic      [pinmux_pkg::PIN_COUNT-1:0] pin_out_o,
  output logic      [pinmux_pkg::PIN_COUNT-1:0] pin_oe_o,
  // Async serial channel 1
  input  wire logic                             async1_serial_clock_out_i,
  input  wire logic                             async1_serial_clock_oe_i,
  output logic                                  async1_serial_clock_in_o,
  output logic                                  async1_rx_data_o,
  input  wire logic                             async1_tx_data_i,
  input  wire logic                             async1_rts_i,
  output logic                                  async1_cts_o,
  // Sync serial channel 2
  output logic                                  sync2_rx_clock_o,
  output logic                                  sync2_rx_frame_sync_o,
  output logic                                  sync2_rx_data_o,
  output logic                                  sync2_tx_clock_o,
  input  wire logic                             sync2_tx_frame_sync_out_i,
  input  wire logic                             sync2_tx_frame_sync_oe_i,
  output logic                                  sync2_tx_frame_sync_in_o,
  // Bus controller status
  input  wire logic                             bus_status_bit1_i,
  input  wire logic                             bus_status_bit0_i,
  // Timers
  input  wire logic                             timer1_capcmp_a_out_i,
  input  wire logic                             timer1_capcmp_a_oe_i,
  output logic                                  timer1_capcmp_a_in_o,
  input  wire logic                             timer1_capcmp_b_out_i,
  input  wire logic                             timer1_capcmp_b_oe_i,
  output logic                                  timer1_capcmp_b_in_o,
  input  wire logic                             timer1_ext_clock_sel_i,
  output logic                                  ext_timer_clock_c_o,
  input  wire logic                             timer2_capcmp_a_out_i,
  input  wire logic                             timer2_capcmp_a_oe_i,
  output logic                                  timer2_capcmp_a_in_o,
  // Lower pins: alternate functions per code
  input  wire logic [pinmux_pkg::HALF_PINS-1:0] low_alt1_out_i,
  input  wire logic [pinmux_pkg::HALF_PINS-1:0] low_alt1_oe_i,
  input  wire logic [pinmux_pkg::HALF_PINS-1:0] low_alt2_out_i,
  input  wire logic [pinmux_pkg::HALF_PINS-1:0] low_alt2_oe_i,
  input  wire logic [pinmux_pkg::HALF_PINS-1:0] low_alt3_out_i,
  input  wire logic [pinmux_pkg::HALF_PINS-1:0] low_alt3_oe_i,
  output logic      [pinmux_pkg::HALF_PINS-1:0] low_alt_in_o
);
  import pinmux_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // Helpers

  // Field of one pin; upper register holds pins 15..8, lower 7..0
  function automatic logic [FIELD_W-1:0] pin_field(
    input logic [REG_W-1:0] upper,
    input logic [REG_W-1:0] lower,
    input int unsigned      pin
  );
    logic [REG_W-1:0] r;
    int unsigned      slot;
    r         = (pin >= HALF_PINS) ? upper : lower;
    slot      = pin % HALF_PINS;
    pin_field = r[FIELD_W*slot +: FIELD_W];
  endfunction : pin_field

  // Reserved codes fall back to general I/O
  function automatic logic [FIELD_W-1:0] eff_mode(
    input logic [FIELD_W-1:0] code,
    input int unsigned        pin
  );
    logic [3:0] legal;
    legal    = MODE_LEGAL[4*pin +: 4];
    eff_mode = legal[code] ? code : MODE_GPIO;
  endfunction : eff_mode

  ////////////////////////////////////////////////////////////////////////////
  // Bus front end and pad synchroniser

  logic [PIN_COUNT-1:0] pin_sync;
  logic [DATA_W-1:0]    rd_data;
  logic                 wr_stb;

  pin_sync pin_sync_i (
    .sys_clk_i (sys_clk_i),
    .reset_n_i (reset_n_i),
    .async_i   (pin_in_i),
    .sync_o    (pin_sync)
  );

  apb_port apb_port_i (
    .sys_clk_i (sys_clk_i),
    .reset_n_i (reset_n_i),
    .psel_i    (psel_i),
    .penable_i (penable_i),
    .pwrite_i  (pwrite_i),
    .paddr_i   (paddr_i),
    .prdata_o  (prdata_o),
    .pready_o  (pready_o),
    .pslverr_o (pslverr_o),
    .rd_data_i (rd_data),
    .wr_stb_o  (wr_stb)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Registers

  logic [REG_W-1:0] upper_func_q, upper_func_d;
  logic [REG_W-1:0] lower_func_q, lower_func_d;
  logic [REG_W-1:0] dir_q, dir_d;
  logic [REG_W-1:0] out_data_q, out_data_d;
  logic [REG_W-1:0] wmask;

  // Only the two low byte lanes carry register bits
  assign wmask = {{8{pstrb_i[1]}}, {8{pstrb_i[0]}}};

  always_comb begin
    upper_func_d = upper_func_q;
    lower_func_d = lower_func_q;
    dir_d        = dir_q;
    out_data_d   = out_data_q;
    if (wr_stb) begin
      unique case (paddr_i)
        OFS_UPPER_FUNC: upper_func_d = (upper_func_q & ~wmask) | (pwdata_i[REG_W-1:0] & wmask);
        OFS_LOWER_FUNC: lower_func_d = (lower_func_q & ~wmask) | (pwdata_i[REG_W-1:0] & wmask);
        OFS_DIRECTION:  dir_d        = (dir_q & ~wmask) | (pwdata_i[REG_W-1:0] & wmask);
        OFS_OUT_DATA:   out_data_d   = (out_data_q & ~wmask) | (pwdata_i[REG_W-1:0] & wmask);
        default:        upper_func_d = upper_func_q;
      endcase
    end
  end

  // Power-on reset is the only clearing source
  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      upper_func_q <= RST_FUNC;
      lower_func_q <= RST_FUNC;
      dir_q        <= RST_DIRECTION;
      out_data_q   <= RST_OUT_DATA;
    end else begin
      upper_func_q <= upper_func_d;
      lower_func_q <= lower_func_d;
      dir_q        <= dir_d;
      out_data_q   <= out_data_d;
    end
  end

  always_comb begin
    rd_data = '0;
    unique case (paddr_i)
      OFS_UPPER_FUNC: rd_data[REG_W-1:0] = upper_func_q;
      OFS_LOWER_FUNC: rd_data[REG_W-1:0] = lower_func_q;
      OFS_DIRECTION:  rd_data[REG_W-1:0] = dir_q;
      OFS_OUT_DATA:   rd_data[REG_W-1:0] = out_data_q;
      OFS_PIN_LEVEL:  rd_data[REG_W-1:0] = pin_sync;
      default:        rd_data = '0;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Mode decode

  logic [FIELD_W-1:0] mode [PIN_COUNT];

  generate
    for (genvar g = 0; g < PIN_COUNT; g++) begin : g_mode
      assign mode[g] = eff_mode(pin_field(upper_func_q, lower_func_q, g), g);
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // Pad drive and peripheral inputs

  logic [PIN_COUNT-1:0] pin_out_d, pin_out_q;
  logic [PIN_COUNT-1:0] pin_oe_d,  pin_oe_q;
  logic [HALF_PINS-1:0] low_in_d,  low_in_q;
  logic [11:0]          per_in_d,  per_in_q;
  logic                 p9_clock_in;

  assign p9_clock_in = timer1_ext_clock_sel_i;

  always_comb begin
    // General I/O default: direction bit enables the drive
    pin_out_d = out_data_q;
    pin_oe_d  = dir_q;
    low_in_d  = '0;
    per_in_d  = '0;
    per_in_d[1] = 1'b1; // Idle-high receive line when unrouted
    for (int i = 0; i < HALF_PINS; i++) begin
      unique case (mode[i])
        MODE_ALT1: begin pin_out_d[i] = low_alt1_out_i[i]; pin_oe_d[i] = low_alt1_oe_i[i]; end
        MODE_ALT2: begin pin_out_d[i] = low_alt2_out_i[i]; pin_oe_d[i] = low_alt2_oe_i[i]; end
        MODE_ALT3: begin pin_out_d[i] = low_alt3_out_i[i]; pin_oe_d[i] = low_alt3_oe_i[i]; end
        default:   low_in_d[i] = 1'b0;
      endcase
      if (mode[i] != MODE_GPIO) begin
        low_in_d[i] = pin_sync[i];
      end
    end
    if (mode[PIN_SCK] == MODE_ALT2) begin
      pin_out_d[PIN_SCK] = async1_serial_clock_out_i;
      pin_oe_d[PIN_SCK]  = async1_serial_clock_oe_i;
      per_in_d[0]        = pin_sync[PIN_SCK];
    end
    if (mode[PIN_RXD] == MODE_ALT2) begin
      pin_oe_d[PIN_RXD] = 1'b0;
      per_in_d[1]       = pin_sync[PIN_RXD];
    end
    if (mode[PIN_TXD] == MODE_ALT2) begin
      pin_out_d[PIN_TXD] = async1_tx_data_i;
      pin_oe_d[PIN_TXD]  = 1'b1;
    end
    unique case (mode[PIN_P12])
      MODE_ALT1: begin pin_oe_d[PIN_P12] = 1'b0; per_in_d[2] = pin_sync[PIN_P12]; end
      MODE_ALT2: begin pin_out_d[PIN_P12] = async1_rts_i; pin_oe_d[PIN_P12] = 1'b1; end
      MODE_ALT3: begin pin_out_d[PIN_P12] = bus_status_bit1_i; pin_oe_d[PIN_P12] = 1'b1; end
      default:   per_in_d[2] = 1'b0;
    endcase
    unique case (mode[PIN_P11])
      MODE_ALT1: begin pin_oe_d[PIN_P11] = 1'b0; per_in_d[3] = pin_sync[PIN_P11]; end
      MODE_ALT2: begin pin_oe_d[PIN_P11] = 1'b0; per_in_d[4] = pin_sync[PIN_P11]; end
      MODE_ALT3: begin pin_out_d[PIN_P11] = bus_status_bit0_i; pin_oe_d[PIN_P11] = 1'b1; end
      default:   per_in_d[3] = 1'b0;
    endcase
    unique case (mode[PIN_P10])
      MODE_ALT1: begin pin_oe_d[PIN_P10] = 1'b0; per_in_d[5] = pin_sync[PIN_P10]; end
      MODE_ALT2: begin
        pin_out_d[PIN_P10] = timer1_capcmp_a_out_i;
        pin_oe_d[PIN_P10]  = timer1_capcmp_a_oe_i;
        per_in_d[6]        = pin_sync[PIN_P10];
      end
      default:   per_in_d[5] = 1'b0;
    endcase
    unique case (mode[PIN_P9])
      MODE_ALT1: begin pin_oe_d[PIN_P9] = 1'b0; per_in_d[7] = pin_sync[PIN_P9]; end
      MODE_ALT2: begin
        if (p9_clock_in) begin
          pin_oe_d[PIN_P9] = 1'b0;
          per_in_d[9]      = pin_sync[PIN_P9];
        end else begin
          pin_out_d[PIN_P9] = timer1_capcmp_b_out_i;
          pin_oe_d[PIN_P9]  = timer1_capcmp_b_oe_i;
          per_in_d[8]       = pin_sync[PIN_P9];
        end
      end
      default:   per_in_d[7] = 1'b0;
    endcase
    unique case (mode[PIN_P8])
      MODE_ALT1: begin
        pin_out_d[PIN_P8] = sync2_tx_frame_sync_out_i;
        pin_oe_d[PIN_P8]  = sync2_tx_frame_sync_oe_i;
        per_in_d[10]      = pin_sync[PIN_P8];
      end
      MODE_ALT2: begin
        pin_out_d[PIN_P8] = timer2_capcmp_a_out_i;
        pin_oe_d[PIN_P8]  = timer2_capcmp_a_oe_i;
        per_in_d[11]      = pin_sync[PIN_P8];
      end
      default:   per_in_d[10] = 1'b0;
    endcase
  end

  // One register stage on every pad and peripheral signal keeps outputs glitch-free
  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      pin_out_q <= '0;
      pin_oe_q  <= '0;
      low_in_q  <= '0;
      per_in_q  <= 12'h002;
    end else begin
      pin_out_q <= pin_out_d;
      pin_oe_q  <= pin_oe_d;
      low_in_q  <= low_in_d;
      per_in_q  <= per_in_d;
    end
  end

  assign pin_out_o                = pin_out_q;
  assign pin_oe_o                 = pin_oe_q;
  assign low_alt_in_o             = low_in_q;
  assign async1_serial_clock_in_o = per_in_q[0];
  assign async1_rx_data_o         = per_in_q[1];
  assign sync2_rx_clock_o         = per_in_q[2];
  assign sync2_rx_frame_sync_o    = per_in_q[3];
  assign async1_cts_o             = per_in_q[4];
  assign sync2_rx_data_o          = per_in_q[5];
  assign timer1_capcmp_a_in_o     = per_in_q[6];
  assign sync2_tx_clock_o         = per_in_q[7];
  assign timer1_capcmp_b_in_o     = per_in_q[8];
  assign ext_timer_clock_c_o      = per_in_q[9];
  assign sync2_tx_frame_sync_in_o = per_in_q[10];
  assign timer2_capcmp_a_in_o     = per_in_q[11];

  ////////////////////////////////////////////////////////////////////////////
  // Checks

  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!reset_n_i);

  sequence s_upper_write;
    wr_stb && paddr_i == OFS_UPPER_FUNC && pstrb_i[1:0] == 2'h3;
  endsequence

  AST_UPPER_WRITE: assert property (s_upper_write |=> upper_func_q == $past(pwdata_i[15:0]))
    else $error("upper function register did not take the write");
  AST_HOLD_NO_WRITE: assert property (!wr_stb |=> $stable(upper_func_q) && $stable(lower_func_q))
    else $error("function register changed without a write");
  AST_PIN15_FIELD: assert property (upper_func_q[15:14] == 2'h2 |-> mode[PIN_SCK] == MODE_ALT2)
    else $error("pin 15 field not at top of upper register");
  AST_PIN7_FIELD: assert property (lower_func_q[15:14] == 2'h1 |-> mode[7] == MODE_ALT1)
    else $error("pin 7 field not at top of lower register");
  AST_GPIO_DIR: assert property (mode[PIN_RXD] == MODE_GPIO ##1 mode[PIN_RXD] == MODE_GPIO |->
                                 pin_oe_o[PIN_RXD] == $past(dir_q[PIN_RXD]))
    else $error("general I/O drive not following direction");
  AST_SCK_ROUTE: assert property (mode[PIN_SCK] == MODE_ALT2 |=>
                                  pin_oe_o[PIN_SCK] == $past(async1_serial_clock_oe_i))
    else $error("serial clock enable not routed");
  AST_RXD_INPUT: assert property (mode[PIN_RXD] == MODE_ALT2 |=> !pin_oe_o[PIN_RXD] &&
                                  async1_rx_data_o == $past(pin_sync[PIN_RXD]))
    else $error("receive data pin not an input");
  AST_TXD_DRIVE: assert property (mode[PIN_TXD] == MODE_ALT2 |=> pin_oe_o[PIN_TXD] &&
                                  pin_out_o[PIN_TXD] == $past(async1_tx_data_i))
    else $error("transmit data not driven");
  AST_STATUS1: assert property (mode[PIN_P12] == MODE_ALT3 |=>
                                pin_out_o[PIN_P12] == $past(bus_status_bit1_i))
    else $error("status 1 not driven on pin 12");
  AST_CTS_IN: assert property (mode[PIN_P11] == MODE_ALT2 |=> !pin_oe_o[PIN_P11] &&
                               async1_cts_o == $past(pin_sync[PIN_P11]))
    else $error("clear-to-send not taken from pin 11");
  AST_P10_RES: assert property (upper_func_q[5:4] == 2'h3 |=>
                                pin_oe_o[PIN_P10] == $past(dir_q[PIN_P10]))
    else $error("pin 10 reserved code not general I/O");
  AST_P9_CLOCK: assert property (mode[PIN_P9] == MODE_ALT2 && timer1_ext_clock_sel_i |=>
                                 !pin_oe_o[PIN_P9] && !timer1_capcmp_b_in_o)
    else $error("pin 9 drives while timer clock input");
  AST_P9_TIMER: assert property (mode[PIN_P9] == MODE_ALT2 && !timer1_ext_clock_sel_i |=>
                                 pin_oe_o[PIN_P9] == $past(timer1_capcmp_b_oe_i))
    else $error("timer 1 B not routed to pin 9");
  AST_P8_FSYNC: assert property (mode[PIN_P8] == MODE_ALT1 |=>
                                 pin_out_o[PIN_P8] == $past(sync2_tx_frame_sync_out_i))
    else $error("frame sync not routed to pin 8");
  AST_DIR_IGNORED: assert property (mode[PIN_TXD] == MODE_ALT2 && !dir_q[PIN_TXD] |=>
                                    pin_oe_o[PIN_TXD])
    else $error("direction bit acted outside general I/O");
  AST_RESERVED: assert property (upper_func_q[15:14] == 2'h1 |-> mode[PIN_SCK] == MODE_GPIO)
    else $error("reserved code not treated as general I/O");

endmodule : port_b_pinmux

// ### sim/port_b_pinmux_tb_top.sv
// Self-checking bench for the port B pin function multiplexer.
// Assumes the design's APB slave and the byte offsets in pinmux_pkg.
`timescale 1ns/1ps
module port_b_pinmux_tb_top;
  import pinmux_pkg::*;
  logic        sys_clk, reset_n, psel, penable, pwrite;
  logic [11:0] paddr;
  logic [31:0] pwdata, rd, rv;
  logic [15:0] pi, po, pe, sv;
  logic [9:0]  pk;
  logic [7:0]  lo, li;
  logic        err, ev, rx, tc, rdy;
  int          failures, checks_done, cyc;
  port_b_pinmux port_b_pinmux_i (
    .sys_clk_i(sys_clk), .reset_n_i(reset_n), .psel_i(psel), .penable_i(penable),
    .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .pstrb_i(4'hf),
    .prdata_o(rd), .pready_o(rdy), .pslverr_o(err), .pin_in_i(pi), .pin_out_o(po),
    .pin_oe_o(pe), .async1_serial_clock_out_i(sv[0]), .async1_serial_clock_oe_i(sv[1]),
    .async1_serial_clock_in_o(pk[0]), .async1_rx_data_o(rx), .async1_tx_data_i(sv[2]),
    .async1_rts_i(sv[3]), .async1_cts_o(pk[1]), .sync2_rx_clock_o(pk[2]),
    .sync2_rx_frame_sync_o(pk[3]), .sync2_rx_data_o(pk[4]), .sync2_tx_clock_o(pk[5]),
    .sync2_tx_frame_sync_out_i(sv[4]), .sync2_tx_frame_sync_oe_i(sv[5]),
    .sync2_tx_frame_sync_in_o(pk[6]), .bus_status_bit1_i(sv[6]), .bus_status_bit0_i(sv[7]),
    .timer1_capcmp_a_out_i(sv[8]), .timer1_capcmp_a_oe_i(sv[9]),
    .timer1_capcmp_a_in_o(pk[7]), .timer1_capcmp_b_out_i(sv[10]),
    .timer1_capcmp_b_oe_i(sv[11]), .timer1_capcmp_b_in_o(pk[8]),
    .timer1_ext_clock_sel_i(sv[12]), .ext_timer_clock_c_o(tc),
    .timer2_capcmp_a_out_i(sv[13]), .timer2_capcmp_a_oe_i(sv[14]),
    .timer2_capcmp_a_in_o(pk[9]), .low_alt1_out_i(lo), .low_alt1_oe_i(lo),
    .low_alt2_out_i(lo), .low_alt2_oe_i(lo), .low_alt3_out_i(lo),
    .low_alt3_oe_i(lo), .low_alt_in_o(li)
  );
  //////////////////////////////////////////////////////////////////////////////
  always #2.5 sys_clk = ~sys_clk;
  // Cut a hang short well past the roughly 60 cycles the tests need
  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    if (cyc == 2000) begin
      failures++;
      end_of_test();
    end
  end
  task end_of_test();
    $display("checks %0d mismatches %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : end_of_test
  task check(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      failures++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  // Request held until pready is seen high; answer taken at that same edge
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    do @(posedge sys_clk); while (rdy !== 1'b1);
    rv = rd;
    ev = err;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  //////////////////////////////////////////////////////////////////////////////
  initial begin
    sys_clk = 0; reset_n = 0; psel = 0; penable = 0; pwrite = 0; paddr = 12'h000;
    pwdata = 32'h0; pi = 16'h0200; sv = 16'h1044; lo = 8'h5a;
    failures = 0; checks_done = 0; cyc = 0;
    repeat (2) @(posedge sys_clk);
    reset_n <= 1'b1;
    apb(0, OFS_UPPER_FUNC, 0); check(rv, 32'h0);
    apb(0, OFS_LOWER_FUNC, 0); check(rv, 32'h0);
    check(pe, 16'h0000);
    $display("reset values done");
    // Pin 15 reserved, 14 rx, 13 tx, 12 status 1
    apb(1, OFS_UPPER_FUNC, 32'h6b00);
    apb(1, OFS_DIRECTION, 32'h8000);
    apb(0, OFS_UPPER_FUNC, 0); check(rv, 32'h6b00);
    apb(1, OFS_LOWER_FUNC, 32'hffff65c3);
    apb(0, OFS_LOWER_FUNC, 0); check(rv, 32'h000065c3);
    apb(0, 12'h014, 0);
    check(ev, 1'b1);
    check(rv, 32'h0);
    repeat (4) @(posedge sys_clk);
    check({po[13], pe[13], po[12], pe[12], pe[15], pe[14], rx}, 7'b1111100);
    check({po[7:0], pe[7:0]}, 16'h5858);
    $display("upper routing done");
    // Timer mode on pin 9 with external clock chosen turns it into an input
    apb(1, OFS_UPPER_FUNC, 32'h0008);
    repeat (4) @(posedge sys_clk);
    check({tc, pe[9]}, 2'b10);
    $display("timer clock done");
    // Pin 15 clock with its drive off, 13 and 10 reserved, serial 2 inputs, clear-to-send
    sv <= 16'h0031;
    pi <= 16'h1b83;
    apb(1, OFS_UPPER_FUNC, 32'h85b5);
    repeat (4) @(posedge sys_clk);
    check(po[15:8], 8'h81);
    check(pe[15:8], 8'h01);
    check({tc, pk}, 11'h066);
    check(li, 8'h81);
    apb(0, OFS_PIN_LEVEL, 0);
    check(rv, 32'h00001b83);
    $display("serial routing done");
    // Request-to-send, status 0 and the three timer lines
    sv <= 16'h4d88;
    apb(1, OFS_UPPER_FUNC, 32'h02ea);
    repeat (4) @(posedge sys_clk);
    check(po[15:8], 8'h1e);
    check(pe[15:8], 8'h9b);
    check({rx, tc, pk}, 12'hb00);
    $display("timer routing done");
    reset_n <= 1'b0;
    repeat (2) @(posedge sys_clk);
    reset_n <= 1'b1;
    apb(0, OFS_UPPER_FUNC, 0); check(rv, 32'h0);
    apb(0, OFS_LOWER_FUNC, 0); check(rv, 32'h0);
    check(pe, 16'h0000);
    $display("second reset done");
    end_of_test();
  end
endmodule : port_b_pinmux_tb_top
